// [osc_guard_regs.svh]
`ifndef OSC_GUARD_REGS_SVH
`define OSC_GUARD_REGS_SVH
// ==========================================
// Register offsets
`define ADDR_WRITE_GUARD   10'h2fb
`define ADDR_TEST_TWO      10'h2fc
`define ADDR_OSC_CONFIG    10'h2fa
`define ADDR_CLOCK_SELECT  10'h2f9
`define ADDR_SYNTH         10'h2f4
`define ADDR_REF_DIV       10'h2f5
`define ADDR_PLL_CTRL      10'h2f8
`define ADDR_TRIM_HI       10'h2f2
`define ADDR_TRIM_LO       10'h2f3
`define ADDR_STATUS        10'h2f1
// ==========================================
// Field positions and values
`define GUARD_KEY          8'h26
`define OSC_ENABLE_BIT     7
`define OSC_BW_BIT         6
`define PLL_SEL_BIT        7
`define STAT_STABLE_BIT    0
`define STAT_LOCK_BIT      1
`define TC_OFF_A           4'h0
`define TC_OFF_B           4'h8
`define GUARD_RESET        1'b1
`define FILT_LOCK_EDGES    4'h8
`endif

// [osc_guard_pkg.sv]
`default_nettype none
package osc_guard_pkg;
  typedef struct packed {
    logic       oscillator_enable;
    logic       filter_bandwidth_select;
    logic       spare;
    logic [4:0] filter_ratio_field;
  } osc_cfg_t;
  typedef enum logic [2:0] {
    FILT_IDLE  = 3'b001,
    FILT_HUNT  = 3'b010,
    FILT_GOOD  = 3'b100
  } filt_state_t;
endpackage : osc_guard_pkg
`default_nettype wire

// [osc_config_and_write_guard.sv]
// Design decision made here: the address-and-strobe port.
`include "osc_guard_regs.svh"
`default_nettype none
// How it works
// - TC codes 0000 and 1000 disable compensation
// - Config write needs guard clear, PLL select
// - Accepted config write clears lock, stable
// - Enable selects oscillator reference, monitor on
// - Lost oscillation raises clock monitor reset
// - Stable flag gates oscillator clock selection
// - Edge window one or three VCO cycles
// - Zero ratio disables filter, else enabled
// - Filter cleans clock, reports stable flag
// - Key 0x26 clears guard, else sets
// - Guard blocks all clock configuration writes
// - Guard register accessible at any time
// - Test register writable only in special
// - Lock flag follows lock tolerance window
module osc_config_and_write_guard
  import osc_guard_pkg::*;
#(
  parameter int MON_TIMEOUT = 16
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       special_mode,
  input  wire logic       vco_output_clock,
  input  wire logic       ext_oscillator_clock,
  input  wire logic       pll_in_lock_tol,
  input  wire logic       pll_out_unlock_tol,
  output var  logic       osc_cell_on,
  output var  logic       ref_is_oscillator,
  output var  logic       clock_monitor_on,
  output var  logic       clock_monitor_reset,
  output var  logic       osc_clock_allowed,
  output var  logic       tc_comp_on,
  output var  logic       clean_osc_clock
);
  // Silence counter saturates at 255, so longer timeouts could never fire
  if (MON_TIMEOUT < 2 || MON_TIMEOUT > 255) begin : g_bad_timeout
    $error("MON_TIMEOUT out of range");
  end

  // ==========================================
  // Registers
  osc_cfg_t   osc_cfg, next_osc_cfg;
  logic       cfg_write_guard, next_cfg_write_guard;
  logic [7:0] test_two, next_test_two;
  logic [7:0] clk_sel, next_clk_sel;
  logic [7:0] synth, next_synth, ref_div, next_ref_div, pll_ctrl, next_pll_ctrl;
  logic [7:0] trim_hi, next_trim_hi, trim_lo, next_trim_lo;
  logic       lock_flag, next_lock_flag;
  logic       oscillator_stable_flag, next_stable;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
    return wr && (a == target);
  endfunction : hit

  logic guarded_ok, osc_ok, osc_write;
  logic [3:0] temp_coeff_trim;
  logic filt_good;

  always_comb begin
    guarded_ok = !cfg_write_guard;
    osc_ok     = guarded_ok && clk_sel[`PLL_SEL_BIT];
    osc_write  = hit(addr, `ADDR_OSC_CONFIG) && osc_ok;
    temp_coeff_trim = trim_hi[7:4];
    next_osc_cfg = osc_cfg;
    if (osc_write) next_osc_cfg = osc_cfg_t'({wdata[7:6], 1'b0, wdata[4:0]});
    next_cfg_write_guard = cfg_write_guard;
    if (hit(addr, `ADDR_WRITE_GUARD)) begin
      next_cfg_write_guard = (wdata != `GUARD_KEY);
    end
    next_test_two = test_two;
    if (hit(addr, `ADDR_TEST_TWO) && special_mode) next_test_two = wdata;
    next_clk_sel = clk_sel;
    if (hit(addr, `ADDR_CLOCK_SELECT) && guarded_ok) begin
      next_clk_sel = wdata;
      // Oscillator cannot become bus clock source until stable
      if (!oscillator_stable_flag) next_clk_sel[0] = clk_sel[0];
    end
    next_synth    = (hit(addr, `ADDR_SYNTH) && guarded_ok)    ? wdata : synth;
    next_ref_div  = (hit(addr, `ADDR_REF_DIV) && guarded_ok)  ? wdata : ref_div;
    next_pll_ctrl = (hit(addr, `ADDR_PLL_CTRL) && guarded_ok) ? wdata : pll_ctrl;
    next_trim_hi  = (hit(addr, `ADDR_TRIM_HI) && guarded_ok)  ? wdata : trim_hi;
    next_trim_lo  = (hit(addr, `ADDR_TRIM_LO) && guarded_ok)  ? wdata : trim_lo;
    next_lock_flag = lock_flag;
    if (pll_in_lock_tol) next_lock_flag = 1'b1;
    else if (pll_out_unlock_tol) next_lock_flag = 1'b0;
    // Filter disabled: stable as soon as edges are seen
    next_stable = osc_cfg.oscillator_enable && filt_good;
    if (osc_write) begin
      next_lock_flag = 1'b0;
      next_stable    = 1'b0;
    end
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADDR_WRITE_GUARD:  next_rdata = {7'h00, cfg_write_guard};
        `ADDR_TEST_TWO:     next_rdata = test_two;
        `ADDR_OSC_CONFIG:   next_rdata = osc_cfg;
        `ADDR_CLOCK_SELECT: next_rdata = clk_sel;
        `ADDR_SYNTH:        next_rdata = synth;
        `ADDR_REF_DIV:      next_rdata = ref_div;
        `ADDR_PLL_CTRL:     next_rdata = pll_ctrl;
        `ADDR_TRIM_HI:      next_rdata = trim_hi;
        `ADDR_TRIM_LO:      next_rdata = trim_lo;
        `ADDR_STATUS:       next_rdata = {6'h00, lock_flag, oscillator_stable_flag};
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_cfg <= '0;
      cfg_write_guard <= `GUARD_RESET;
      test_two <= 8'h00;
      clk_sel <= 8'h00;
      synth <= 8'h00;
      ref_div <= 8'h00;
      pll_ctrl <= 8'h00;
      trim_hi <= 8'h00;
      trim_lo <= 8'h00;
      lock_flag <= 1'b0;
      oscillator_stable_flag <= 1'b0;
      rdata <= 8'h00;
    end else begin
      osc_cfg <= next_osc_cfg;
      cfg_write_guard <= next_cfg_write_guard;
      test_two <= next_test_two;
      clk_sel <= next_clk_sel;
      synth <= next_synth;
      ref_div <= next_ref_div;
      pll_ctrl <= next_pll_ctrl;
      trim_hi <= next_trim_hi;
      trim_lo <= next_trim_lo;
      lock_flag <= next_lock_flag;
      oscillator_stable_flag <= next_stable;
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // Adaptive filter, sampled on the system clock
  // Both clock inputs are taken as synchronous samples; real edges finer
  // than the system clock are beyond this model.
  filt_state_t state, next_state;
  logic vco_q, osc_q, next_vco_q, next_osc_q;
  logic [5:0] vco_cnt, next_vco_cnt;
  logic [3:0] good_edges, next_good_edges;
  logic [7:0] silent, next_silent;
  logic       mon_rst, next_mon_rst, clean, next_clean;
  logic       vco_rise, osc_rise, filt_on;
  logic [5:0] expect_cnt, window;
  // One bit wider so the window bounds never wrap at large ratios
  logic [6:0] win_lo, win_hi;

  always_comb begin
    vco_rise = vco_output_clock && !vco_q;
    osc_rise = ext_oscillator_clock && !osc_q;
    filt_on  = osc_cfg.filter_ratio_field != 5'h00;
    expect_cnt = {osc_cfg.filter_ratio_field, 1'b0};
    window = osc_cfg.filter_bandwidth_select ? 6'd3 : 6'd1;
    win_lo = {1'b0, vco_cnt} + {1'b0, window};
    win_hi = {1'b0, expect_cnt} + {1'b0, window};
    next_vco_q = vco_output_clock;
    next_osc_q = ext_oscillator_clock;
    next_state = state;
    next_vco_cnt = vco_cnt;
    next_good_edges = good_edges;
    next_clean = clean;
    if (vco_rise && vco_cnt != 6'h3f) next_vco_cnt = vco_cnt + 6'd1;
    case (state)
      FILT_IDLE: begin
        next_good_edges = 4'h0;
        if (osc_cfg.oscillator_enable) next_state = FILT_HUNT;
      end
      FILT_HUNT, FILT_GOOD: begin
        if (!filt_on) begin
          if (osc_rise) next_good_edges = `FILT_LOCK_EDGES;
          next_clean = ext_oscillator_clock;
        end else if (osc_rise) begin
          next_vco_cnt = 6'h00;
          // Edge outside the window is noise and is dropped
          if (win_lo >= {1'b0, expect_cnt} && {1'b0, vco_cnt} <= win_hi) begin
            next_clean = !clean;
            if (good_edges != `FILT_LOCK_EDGES) next_good_edges = good_edges + 4'h1;
          end else begin
            next_good_edges = 4'h0;
          end
        end
        next_state = (good_edges == `FILT_LOCK_EDGES) ? FILT_GOOD : FILT_HUNT;
        if (!osc_cfg.oscillator_enable) next_state = FILT_IDLE;
      end
      default: next_state = FILT_IDLE;
    endcase

    // A new setting must qualify the crystal afresh
    if (osc_write) begin
      next_state      = FILT_IDLE;
      next_good_edges = 4'h0;
    end
    filt_good = (state == FILT_GOOD);
    next_silent = osc_rise ? 8'h00 : ((silent != 8'hff) ? silent + 8'h01 : silent);
    // Monitor only armed while the oscillator is enabled
    next_mon_rst = osc_cfg.oscillator_enable && (silent >= 8'(MON_TIMEOUT));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= FILT_IDLE;
      vco_q <= 1'b0;
      osc_q <= 1'b0;
      vco_cnt <= 6'h00;
      good_edges <= 4'h0;
      silent <= 8'h00;
      mon_rst <= 1'b0;
      clean <= 1'b0;
    end else begin
      state <= next_state;
      vco_q <= next_vco_q;
      osc_q <= next_osc_q;
      vco_cnt <= next_vco_cnt;
      good_edges <= next_good_edges;
      silent <= next_silent;
      mon_rst <= next_mon_rst;
      clean <= next_clean;
    end
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_cell_on <= 1'b0;
      ref_is_oscillator <= 1'b0;
      clock_monitor_on <= 1'b0;
      clock_monitor_reset <= 1'b0;
      osc_clock_allowed <= 1'b0;
      tc_comp_on <= 1'b0;
      clean_osc_clock <= 1'b0;
    end else begin
      osc_cell_on <= osc_cfg.oscillator_enable;
      ref_is_oscillator <= osc_cfg.oscillator_enable;
      clock_monitor_on <= osc_cfg.oscillator_enable;
      // Gated so a reset never outlives the monitor being switched off
      clock_monitor_reset <= mon_rst && osc_cfg.oscillator_enable;
      osc_clock_allowed <= oscillator_stable_flag;
      tc_comp_on <= (temp_coeff_trim != `TC_OFF_A) && (temp_coeff_trim != `TC_OFF_B);
      clean_osc_clock <= clean;
    end
  end
endmodule : osc_config_and_write_guard
`default_nettype wire

// [osc_guard_sva.sv]
`include "osc_guard_regs.svh"
`default_nettype none
// ====================
// Port checker
module osc_guard_sva #(
  parameter int MON_TIMEOUT = 16
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       ext_oscillator_clock,
  input wire logic       osc_cell_on,
  input wire logic       ref_is_oscillator,
  input wire logic       clock_monitor_on,
  input wire logic       clock_monitor_reset,
  input wire logic       osc_clock_allowed,
  input wire logic       tc_comp_on
);
  logic       guard, next_guard, sel, next_sel, osc_q;
  logic [7:0] quiet, next_quiet;
  // Saturates so a dead crystal never wraps back to zero
  always_comb begin
    next_guard = guard;
    next_sel   = sel;
    next_quiet = (!clock_monitor_on || (ext_oscillator_clock && !osc_q)) ? 8'h00 :
                 (quiet == 8'hff) ? quiet : quiet + 8'h01;
    if (wr && addr == `ADDR_WRITE_GUARD) begin
      next_guard = wdata != `GUARD_KEY;
    end
    if (wr && addr == `ADDR_CLOCK_SELECT && !guard) begin
      next_sel = wdata[`PLL_SEL_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      guard <= `GUARD_RESET;
      sel   <= 1'b0;
      quiet <= 8'h00;
    end else begin
      guard <= next_guard;
      sel   <= next_sel;
      quiet <= next_quiet;
    end
    osc_q <= ext_oscillator_clock;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_key;
    wr && addr == `ADDR_WRITE_GUARD && wdata == `GUARD_KEY;
  endsequence
  sequence s_other;
    wr && addr == `ADDR_WRITE_GUARD && wdata != `GUARD_KEY;
  endsequence
  sequence s_rd_guard;
    rd && addr == `ADDR_WRITE_GUARD;
  endsequence
  property p_unlock;
    s_key ##1 s_rd_guard |=> rdata == 8'h00;
  endproperty
  property p_lock;
    s_other ##1 s_rd_guard |=> rdata == 8'h01;
  endproperty
  property p_guard_read;
    $past(rd) && $past(addr) == `ADDR_WRITE_GUARD |-> rdata == {7'h00, $past(guard)};
  endproperty
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  property p_ref_follow;
    ref_is_oscillator == osc_cell_on && clock_monitor_on == osc_cell_on;
  endproperty
  property p_mon_fire;
    clock_monitor_on && quiet >= 8'(MON_TIMEOUT + 3) |-> clock_monitor_reset;
  endproperty
  property p_mon_on;
    clock_monitor_reset |-> clock_monitor_on;
  endproperty
  property p_tc;
    $past(rd) && $past(addr) == `ADDR_TRIM_HI |-> tc_comp_on == (rdata[6:4] != 3'h0);
  endproperty
  property p_cfg_clear;
    wr && addr == `ADDR_OSC_CONFIG && !guard && sel |-> ##2 !osc_clock_allowed;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key left guard set");
  a_lock: assert property (p_lock) else $error("guard not set");
  a_guard_read: assert property (p_guard_read) else $error("guard read");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  a_ref_follow: assert property (p_ref_follow) else $error("enable copies");
  a_mon_fire: assert property (p_mon_fire) else $error("monitor silent");
  a_mon_on: assert property (p_mon_on) else $error("monitor off");
  a_tc: assert property (p_tc) else $error("tc compensation");
  a_cfg_clear: assert property (p_cfg_clear) else $error("stable kept");
endmodule : osc_guard_sva
`default_nettype wire

// [osc_source_model.sv]
`default_nettype none
// ====================
// Crystal and VCO source
module osc_source_model #(
  parameter int HALF = 2
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output var  logic osc_clk,
  output var  logic vco_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial osc_clk = 1'b0;
  initial vco_clk = 1'b0;
  always @(posedge clk_sys) begin
    vco_clk <= !vco_clk;
    if (!run) begin
      cnt <= 0; // Dead crystal holds its level
    end else if (cnt == HALF - 1) begin
      cnt     <= 0;
      osc_clk <= !osc_clk; // Clean steady source
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : osc_source_model
`default_nettype wire

// [osc_config_and_write_guard_tb.sv]
`include "osc_guard_regs.svh"
`default_nettype none
// ====================
// Bench
module osc_config_and_write_guard_tb import osc_guard_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MON = 8;
  logic clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, run = 1'b1;
  logic special_mode = 1'b0, pll_in_lock_tol = 1'b0, pll_out_unlock_tol = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic ext_oscillator_clock, vco_output_clock, osc_cell_on, ref_is_oscillator;
  logic clock_monitor_on, clock_monitor_reset, osc_clock_allowed, tc_comp_on, clean;
  int bad_count = 0, checked = 0, seed = 32'h8279_e6d6;
  logic [7:0] exp_q[$];
  osc_cfg_t cfg;
  initial forever #12.5 clk_sys = ~clk_sys;
  osc_config_and_write_guard #(.MON_TIMEOUT(MON)) dut (.clk_sys, .rst, .addr, .wdata,
    .wr, .rd, .rdata, .special_mode, .vco_output_clock, .ext_oscillator_clock,
    .pll_in_lock_tol, .pll_out_unlock_tol, .osc_cell_on, .ref_is_oscillator,
    .clock_monitor_on, .clock_monitor_reset, .osc_clock_allowed, .tc_comp_on,
    .clean_osc_clock(clean));
  osc_source_model #(.HALF(2)) src (.clk_sys, .run, .osc_clk(ext_oscillator_clock),
    .vco_clk(vco_output_clock));
  task automatic check(input logic [7:0] seen, input logic [7:0] e, input string what);
    checked++;
    if (seen !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // Strobes stay up until the next call, so back-to-back cycles never double-assign
  task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [7:0] v);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= v;
    if (r) exp_q.push_back(v);
    @(posedge clk_sys);
  endtask : bus
  task automatic flag(ref logic sig, input logic e, input string what);
    bus(1'b0, 1'b0, 10'h000, 8'h00);
    @(negedge clk_sys);
    check({7'h00, sig}, {7'h00, e}, what);
    @(posedge clk_sys);
  endtask : flag
  task automatic wait_hi(ref logic sig, input int lim, input string what);
    int n;
    n = 0;
    bus(1'b0, 1'b0, 10'h000, 8'h00);
    while (sig !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check({7'h00, sig}, 8'h01, what);
    if (sig !== 1'b1) summarize();
  endtask : wait_hi
  always @(posedge clk_sys) begin
    rd_q <= rd;
    if (rd_q) check(rdata, exp_q.pop_front(), "rdata");
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 1, `ADDR_WRITE_GUARD, 8'h01);
    bus(1, 0, `ADDR_CLOCK_SELECT, 8'h80);
    bus(1, 0, `ADDR_TRIM_HI, 8'h90);
    bus(0, 1, `ADDR_CLOCK_SELECT, 8'h00);
    bus(0, 1, `ADDR_TRIM_HI, 8'h00);
    bus(0, 1, 10'h3ff, 8'h00);
    pll_in_lock_tol <= 1'b1;
    bus(0, 0, 10'h000, 8'h00);
    pll_in_lock_tol    <= 1'b0;
    pll_out_unlock_tol <= 1'b1;
    bus(0, 1, `ADDR_STATUS, 8'h02);
    pll_out_unlock_tol <= 1'b0;
    bus(0, 1, `ADDR_STATUS, 8'h00);
    d = 8'($random(seed));
    bus(1, 0, `ADDR_TEST_TWO, d);
    bus(0, 1, `ADDR_TEST_TWO, 8'h00);
    special_mode <= 1'b1;
    bus(1, 0, `ADDR_TEST_TWO, 8'h5a);
    bus(0, 1, `ADDR_TEST_TWO, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      d = (i == 7) ? `GUARD_KEY : 8'($random(seed));
      bus(1, 0, `ADDR_WRITE_GUARD, d);
      bus(0, 1, `ADDR_WRITE_GUARD, {7'h00, d != `GUARD_KEY});
    end
    special_mode <= 1'b0;
    cfg = '{1'b1, 1'b1, 1'b0, 5'h00}; // Wide band, filter off
    bus(1, 0, `ADDR_OSC_CONFIG, cfg);
    bus(0, 1, `ADDR_OSC_CONFIG, 8'h00);
    pll_in_lock_tol <= 1'b1;
    bus(1, 0, `ADDR_CLOCK_SELECT, 8'h81);
    pll_in_lock_tol <= 1'b0;
    bus(0, 1, `ADDR_CLOCK_SELECT, 8'h80);
    bus(1, 0, `ADDR_OSC_CONFIG, cfg);
    bus(0, 1, `ADDR_STATUS, 8'h00);
    bus(0, 1, `ADDR_OSC_CONFIG, cfg);
    flag(ref_is_oscillator, 1'b1, "ref_is_oscillator");
    wait_hi(osc_clock_allowed, 200, "osc_clock_allowed");
    bus(1, 0, `ADDR_CLOCK_SELECT, 8'h81);
    bus(0, 1, `ADDR_CLOCK_SELECT, 8'h81);
    bus(1, 0, `ADDR_OSC_CONFIG, cfg);
    flag(osc_clock_allowed, 1'b0, "osc_clock_allowed");
    for (int c = 0; c < 16; c++) begin
      bus(1, 0, `ADDR_TRIM_HI, 8'(c << 4));
      bus(0, 1, `ADDR_TRIM_HI, 8'(c << 4));
      flag(tc_comp_on, c[2:0] != 3'h0, "tc_comp_on");
    end
    // Ratio one: two VCO edges per crystal period
    bus(1, 0, `ADDR_OSC_CONFIG, 8'h81);
    wait_hi(osc_clock_allowed, 200, "narrow stable");
    d = {7'h00, clean};
    repeat (4) @(posedge clk_sys);
    check({7'h00, clean}, {7'h00, !d[0]}, "clean toggle");
    bus(1, 0, `ADDR_OSC_CONFIG, 8'h82);
    bus(0, 0, 10'h000, 8'h00);
    repeat (60) @(posedge clk_sys);
    d = {7'h00, clean};
    flag(osc_clock_allowed, 1'b0, "narrow refused");
    check({7'h00, clean}, d, "noise dropped");
    cfg = 8'hc2;
    bus(1, 0, `ADDR_OSC_CONFIG, cfg);
    wait_hi(osc_clock_allowed, 200, "wide stable");
    bus(1, 0, `ADDR_WRITE_GUARD, 8'h00);
    bus(1, 0, `ADDR_OSC_CONFIG, 8'h00);
    bus(0, 1, `ADDR_OSC_CONFIG, cfg);
    flag(osc_cell_on, 1'b1, "osc_cell_on");
    run <= 1'b0;
    wait_hi(clock_monitor_reset, MON + 10, "clock_monitor_reset");
    summarize();
  end
endmodule : osc_config_and_write_guard_tb
bind osc_config_and_write_guard osc_guard_sva #(.MON_TIMEOUT(MON_TIMEOUT)) chk (.clk_sys,
  .rst, .addr, .wdata, .wr, .rd, .rdata, .ext_oscillator_clock, .osc_cell_on,
  .ref_is_oscillator, .clock_monitor_on, .clock_monitor_reset, .osc_clock_allowed,
  .tc_comp_on);
`default_nettype wire
